// File: mba_pkg.sv
package mba_pkg;

    // Operation codes carried from the requester to the bank logic.
    typedef enum logic [3:0] {
        OP_DIR       = 4'b0000, // mem and mem.bit direct forms.
        OP_HL        = 4'b0001,
        OP_HL_INC    = 4'b0010,
        OP_HL_DEC    = 4'b0011,
        OP_DE        = 4'b0100,
        OP_DL        = 4'b0101,
        OP_FMEM      = 4'b0110,
        OP_PMEM      = 4'b0111,
        OP_HREL      = 4'b1000,
        OP_STACK     = 4'b1001,
        OP_SET_EN    = 4'b1010,
        OP_CLR_EN    = 4'b1011,
        OP_SEL_BANK  = 4'b1100,
        OP_SEL_STACK = 4'b1101,
        OP_CALL      = 4'b1110,
        OP_RET       = 4'b1111
    } mba_op_t;

    // Address map of the data space.
    localparam logic [11:0] RAM_LAST   = 12'h03ff;
    localparam logic [11:0] PER_FIRST  = 12'h0f80;
    localparam logic [3:0]  BANK_PER   = 4'hf;
    localparam logic [3:0]  BANK_RAM_0 = 4'h0;
    localparam logic [3:0]  BANK_RAM_3 = 4'h3;
    localparam logic [7:0]  DIR_HIGH   = 8'h80;

    // Reset values of the bank state.
    localparam logic        RST_ENABLE = 1'b0;
    localparam logic [3:0]  RST_BANK   = 4'h0;
    localparam logic [1:0]  RST_STACK  = 2'h0;
    localparam int          SAVE_DEPTH = 8;

    // Controller register offsets on APB.
    localparam logic [11:0] OFF_CMD    = 12'h000;
    localparam logic [11:0] OFF_INDEX  = 12'h004;
    localparam logic [11:0] OFF_STATUS = 12'h008;

    // Command register fields.
    localparam int CMD_OP_LSB  = 0;
    localparam int CMD_WIDE    = 4;
    localparam int CMD_BIT_LSB = 5;
    localparam int CMD_OPD_LSB = 8;

    // Index register fields.
    localparam int IDX_H_LSB  = 0;
    localparam int IDX_L_LSB  = 4;
    localparam int IDX_D_LSB  = 8;
    localparam int IDX_E_LSB  = 12;
    localparam int IDX_SP_LSB = 16;

    // Status register fields.
    localparam int ST_ADDR_LSB = 0;
    localparam int ST_BIT_LSB  = 12;
    localparam int ST_RAM      = 14;
    localparam int ST_PER      = 15;
    localparam int ST_FAULT    = 16;
    localparam int ST_BUSY     = 17;
    localparam int ST_FLAG     = 18;
    localparam int ST_BANK_LSB = 20;

endpackage

// File: mba_if.sv
`timescale 1ns/1ps
interface mba_if;

    // Request from the decoder side.
    logic                req;
    mba_pkg::mba_op_t    op;
    logic                wide;
    logic [7:0]          operand;
    logic [1:0]          bitsel;
    logic [3:0]          reg_h;
    logic [3:0]          reg_l;
    logic [3:0]          reg_d;
    logic [3:0]          reg_e;
    logic [7:0]          sp;

    // Answer from the bank logic.
    logic                ack;
    logic [11:0]         addr;
    logic [1:0]          bit_num;
    logic                ram_sel;
    logic                per_sel;
    logic                fault;
    logic                flag;
    logic [3:0]          bank;

    modport dev (
        input  req, op, wide, operand, bitsel, reg_h, reg_l, reg_d, reg_e, sp,
        output ack, addr, bit_num, ram_sel, per_sel, fault, flag, bank
    );

    modport host (
        output req, op, wide, operand, bitsel, reg_h, reg_l, reg_d, reg_e, sp,
        input  ack, addr, bit_num, ram_sel, per_sel, fault, flag, bank
    );

endinterface

// File: mba_host.sv
`timescale 1ns/1ps
module mba_host (
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Link to the bank logic.
    mba_if.host              link
);

    typedef struct packed {
        logic             pready;
        logic             pslverr;
        logic [31:0]      prdata;
        logic             req;
        logic [3:0]       op;
        logic             wide;
        logic [7:0]       operand;
        logic [1:0]       bitsel;
        logic [3:0]       reg_h;
        logic [3:0]       reg_l;
        logic [3:0]       reg_d;
        logic [3:0]       reg_e;
        logic [7:0]       sp;
        logic             busy;
        logic [11:0]      addr;
        logic [1:0]       bit_num;
        logic             ram_sel;
        logic             per_sel;
        logic             fault;
    } mba_host_state_t;

    // Width of the index register image.
    localparam int IDXW = 24;

    mba_host_state_t st_reg;
    mba_host_state_t st_next;
    logic            access;
    logic            done;
    logic [7:0]      hl_sum;

    // Access phase and its final edge.
    assign access = psel & penable;
    assign done   = access & st_reg.pready;

    // Next state of the controller.
    always_comb begin
        st_next         = st_reg;
        st_next.req     = 1'b0;
        st_next.pready  = access & ~st_reg.pready;
        st_next.pslverr = 1'b0;
        hl_sum          = {st_reg.reg_h, st_reg.reg_l};
        if (access & ~st_reg.pready) begin
            st_next.pslverr = ~(paddr == mba_pkg::OFF_CMD || paddr == mba_pkg::OFF_INDEX
                                || paddr == mba_pkg::OFF_STATUS);
            st_next.prdata  = 32'h0000_0000;
            if (paddr == mba_pkg::OFF_INDEX) begin
                st_next.prdata[IDXW-1:0] = {st_reg.sp, st_reg.reg_e, st_reg.reg_d,
                                            st_reg.reg_l, st_reg.reg_h};
            end else if (paddr == mba_pkg::OFF_STATUS) begin
                st_next.prdata[mba_pkg::ST_ADDR_LSB +: 12] = st_reg.addr;
                st_next.prdata[mba_pkg::ST_BIT_LSB +: 2]   = st_reg.bit_num;
                st_next.prdata[mba_pkg::ST_RAM]            = st_reg.ram_sel;
                st_next.prdata[mba_pkg::ST_PER]            = st_reg.per_sel;
                st_next.prdata[mba_pkg::ST_FAULT]          = st_reg.fault;
                st_next.prdata[mba_pkg::ST_BUSY]           = st_reg.busy;
                st_next.prdata[mba_pkg::ST_FLAG]           = link.flag;
                st_next.prdata[mba_pkg::ST_BANK_LSB +: 4]  = link.bank;
            end
        end
        // Writes land only on the edge that ends the access phase.
        if (done & pwrite) begin
            if (paddr == mba_pkg::OFF_CMD && !st_reg.busy) begin
                st_next.op      = pwdata[mba_pkg::CMD_OP_LSB +: 4];
                st_next.wide    = pwdata[mba_pkg::CMD_WIDE];
                st_next.bitsel  = pwdata[mba_pkg::CMD_BIT_LSB +: 2];
                st_next.operand = pwdata[mba_pkg::CMD_OPD_LSB +: 8];
                st_next.req     = 1'b1;
                st_next.busy    = 1'b1;
            end else if (paddr == mba_pkg::OFF_INDEX && !st_reg.busy) begin
                st_next.reg_h = pwdata[mba_pkg::IDX_H_LSB +: 4];
                st_next.reg_l = pwdata[mba_pkg::IDX_L_LSB +: 4];
                st_next.reg_d = pwdata[mba_pkg::IDX_D_LSB +: 4];
                st_next.reg_e = pwdata[mba_pkg::IDX_E_LSB +: 4];
                st_next.sp    = pwdata[mba_pkg::IDX_SP_LSB +: 8];
            end
        end
        // Capture the answer and step the primary pair for the post forms.
        if (link.ack) begin
            st_next.busy    = 1'b0;
            st_next.addr    = link.addr;
            st_next.bit_num = link.bit_num;
            st_next.ram_sel = link.ram_sel;
            st_next.per_sel = link.per_sel;
            st_next.fault   = link.fault;
            if (st_reg.op == mba_pkg::OP_HL_INC) begin
                hl_sum = 8'({st_reg.reg_h, st_reg.reg_l} + 8'h01);
            end else if (st_reg.op == mba_pkg::OP_HL_DEC) begin
                hl_sum = 8'({st_reg.reg_h, st_reg.reg_l} - 8'h01);
            end
            st_next.reg_h = hl_sum[7:4];
            st_next.reg_l = hl_sum[3:0];
        end
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state flops.
    assign prdata       = st_reg.prdata;
    assign pready       = st_reg.pready;
    assign pslverr      = st_reg.pslverr;
    assign link.req     = st_reg.req;
    assign link.op      = mba_pkg::mba_op_t'(st_reg.op);
    assign link.wide    = st_reg.wide;
    assign link.operand = st_reg.operand;
    assign link.bitsel  = st_reg.bitsel;
    assign link.reg_h   = st_reg.reg_h;
    assign link.reg_l   = st_reg.reg_l;
    assign link.reg_d   = st_reg.reg_d;
    assign link.reg_e   = st_reg.reg_e;
    assign link.sp      = st_reg.sp;

endmodule

// File: mba_device.sv
`timescale 1ns/1ps
// Overview of operation
// - Address is bank nibble over eight-bit low byte.
// - 000H-3FFH is RAM, F80H-FFFH peripherals.
// - Bank select holds only 0-3 or 15.
// - Enable flag saved on call, restored on return.
// - Direct forms: flag 0 splits banks 0/15.
// - Requester gives even operand for byte access.
// - Primary pair indirect uses flag AND select.
// - Requester keeps L even for byte access.
// - Secondary and mixed pairs always bank 0.
// - Fixed bit area: FB0H-FBFH and FF0H-FFFH only.
// - Port bit area: operand, L[3:2], bit L[1:0].
// - H-relative bits: bank, H, operand low nibble.
// - Stack uses pointer in stack bank 0-3.
// - Software normally keeps enable flag set.
// - Flag set/cleared singly; select loaded by command.
module mba_device #(
    parameter int SAVE_DEPTH = mba_pkg::SAVE_DEPTH
) (
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Link from the decoder side.
    mba_if.dev               link,
    // Memory side.
    output logic             mem_strobe,
    output logic [11:0]      mem_addr,
    output logic [1:0]       mem_bit,
    output logic             mem_wide,
    output logic             ram_cs,
    output logic             per_cs,
    // Bank state for observation.
    output logic             bank_enable_flag,
    output logic [3:0]       bank_select_value,
    output logic [1:0]       stack_bank_select
);

    // The save stack needs room to shift in and out.
    if (SAVE_DEPTH < 2) begin : g_depth_check
        $error("SAVE_DEPTH must be at least 2");
    end

    typedef struct packed {
        logic                  flag;
        logic [3:0]            bank;
        logic [1:0]            sbank;
        logic [SAVE_DEPTH-1:0] saved;
        logic                  ack;
        logic                  strobe;
        logic [11:0]           addr;
        logic [1:0]            bit_num;
        logic                  wide;
        logic                  ram;
        logic                  per;
        logic                  fault;
    } mba_dev_state_t;

    mba_dev_state_t st_reg;
    mba_dev_state_t st_next;

    // Bank used by the primary-pair indirect and H-relative forms.
    function automatic logic [3:0] effective_bank(input logic flag, input logic [3:0] sel);
        effective_bank = sel & {4{flag}};
    endfunction

    // Bank used by the direct forms.
    function automatic logic [3:0] direct_bank(input logic flag, input logic [3:0] sel,
                                               input logic [7:0] opd);
        if (flag) begin
            direct_bank = sel;
        end else if (opd >= mba_pkg::DIR_HIGH) begin
            direct_bank = mba_pkg::BANK_PER;
        end else begin
            direct_bank = mba_pkg::BANK_RAM_0;
        end
    endfunction

    // Legal values of the bank select.
    function automatic logic bank_legal(input logic [3:0] v);
        bank_legal = (v <= mba_pkg::BANK_RAM_3) || (v == mba_pkg::BANK_PER);
    endfunction

    // Next state of the bank logic.
    always_comb begin
        st_next        = st_reg;
        st_next.ack    = 1'b0;
        st_next.strobe = 1'b0;
        if (link.req) begin
            st_next.ack     = 1'b1;
            st_next.wide    = link.wide;
            st_next.bit_num = link.bitsel;
            st_next.fault   = 1'b0;
            case (link.op)
                mba_pkg::OP_DIR: begin
                    st_next.addr  = {direct_bank(st_reg.flag, st_reg.bank, link.operand),
                                     link.operand};
                    st_next.fault = link.wide & link.operand[0];
                end
                mba_pkg::OP_HL, mba_pkg::OP_HL_INC, mba_pkg::OP_HL_DEC: begin
                    st_next.addr  = {effective_bank(st_reg.flag, st_reg.bank),
                                     link.reg_h, link.reg_l};
                    st_next.fault = link.wide & link.reg_l[0];
                end
                mba_pkg::OP_DE: begin
                    st_next.addr = {mba_pkg::BANK_RAM_0, link.reg_d, link.reg_e};
                end
                mba_pkg::OP_DL: begin
                    st_next.addr = {mba_pkg::BANK_RAM_0, link.reg_d, link.reg_l};
                end
                mba_pkg::OP_FMEM: begin
                    // Only the two sixteen-nibble windows can be formed.
                    st_next.addr = {mba_pkg::BANK_PER, 1'b1, link.operand[6], 2'b11,
                                    link.operand[3:0]};
                end
                mba_pkg::OP_PMEM: begin
                    // The top two operand bits are forced to stay in FC0H-FFFH.
                    st_next.addr    = {mba_pkg::BANK_PER, 2'b11, link.operand[5:2],
                                       link.reg_l[3:2]};
                    st_next.bit_num = link.reg_l[1:0];
                end
                mba_pkg::OP_HREL: begin
                    st_next.addr = {effective_bank(st_reg.flag, st_reg.bank), link.reg_h,
                                    link.operand[3:0]};
                end
                mba_pkg::OP_STACK: begin
                    st_next.addr = {2'b00, st_reg.sbank, link.sp};
                end
                mba_pkg::OP_SET_EN: begin
                    st_next.flag = 1'b1;
                end
                mba_pkg::OP_CLR_EN: begin
                    st_next.flag = 1'b0;
                end
                mba_pkg::OP_SEL_BANK: begin
                    // An illegal value leaves the select unchanged and reports a fault.
                    if (bank_legal(link.operand[3:0])) begin
                        st_next.bank = link.operand[3:0];
                    end else begin
                        st_next.fault = 1'b1;
                    end
                end
                mba_pkg::OP_SEL_STACK: begin
                    // Only banks 0 to 3 fit the two-bit stack bank select.
                    st_next.sbank = link.operand[1:0];
                    st_next.fault = |link.operand[3:2];
                end
                mba_pkg::OP_CALL: begin
                    st_next.saved = {st_reg.saved[SAVE_DEPTH-2:0], st_reg.flag};
                end
                mba_pkg::OP_RET: begin
                    st_next.flag  = st_reg.saved[0];
                    st_next.saved = {1'b0, st_reg.saved[SAVE_DEPTH-1:1]};
                end
                default: begin
                    st_next.fault = 1'b1;
                end
            endcase
            // Decode of the data space; the gap between the two areas is unmapped.
            st_next.ram = st_next.addr <= mba_pkg::RAM_LAST;
            st_next.per = st_next.addr >= mba_pkg::PER_FIRST;
            if (link.op >= mba_pkg::OP_SET_EN) begin
                st_next.ram = 1'b0;
                st_next.per = 1'b0;
            end
            // Faulted or unmapped accesses are not strobed.
            st_next.strobe = ~st_next.fault & (st_next.ram | st_next.per);
        end
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg       <= '0;
            st_reg.flag  <= mba_pkg::RST_ENABLE;
            st_reg.bank  <= mba_pkg::RST_BANK;
            st_reg.sbank <= mba_pkg::RST_STACK;
        end else begin
            st_reg <= st_next;
        end
    end

    // Link answer straight from the state flops.
    assign link.ack     = st_reg.ack;
    assign link.addr    = st_reg.addr;
    assign link.bit_num = st_reg.bit_num;
    assign link.ram_sel = st_reg.ram;
    assign link.per_sel = st_reg.per;
    assign link.fault   = st_reg.fault;
    assign link.flag    = st_reg.flag;
    assign link.bank    = st_reg.bank;

    // Memory side straight from the state flops.
    assign mem_strobe        = st_reg.strobe;
    assign mem_addr          = st_reg.addr;
    assign mem_bit           = st_reg.bit_num;
    assign mem_wide          = st_reg.wide;
    assign ram_cs            = st_reg.ram;
    assign per_cs            = st_reg.per;
    assign bank_enable_flag  = st_reg.flag;
    assign bank_select_value = st_reg.bank;
    assign stack_bank_select = st_reg.sbank;

endmodule

// File: mba_assertions.sv
`timescale 1ns/1ps
module mba_assertions (
    // Clock and reset.
    input logic             pclk,
    input logic             presetn,
    // Request side of the link.
    input logic             req,
    input mba_pkg::mba_op_t op,
    input logic             wide,
    input logic [7:0]       operand,
    input logic [1:0]       bitsel,
    input logic [3:0]       reg_h,
    input logic [3:0]       reg_l,
    input logic [3:0]       reg_d,
    input logic [3:0]       reg_e,
    input logic [7:0]       sp,
    // Answer side of the link.
    input logic             ack,
    input logic [11:0]      addr,
    input logic [1:0]       bit_num,
    input logic             ram_sel,
    input logic             per_sel,
    input logic             fault,
    input logic             flag,
    input logic [3:0]       bank
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Each request gets exactly one answer pulse on the next edge.
    ack_timing_a: assert property (req |=> ack ##1 !ack)
        else $error("answer pulse does not follow request");
    // Direct forms split banks 0 and 15 on the top operand bit while the flag is clear.
    dir_bank_a: assert property (req && op == mba_pkg::OP_DIR && !wide |=>
        addr == {$past(flag) ? $past(bank) : {4{$past(operand[7])}}, $past(operand)})
        else $error("direct address has wrong bank");
    // Primary pair forms use the flag masked select value as bank.
    hl_bank_a: assert property (req && !wide && op inside {mba_pkg::OP_HL,
        mba_pkg::OP_HL_INC, mba_pkg::OP_HL_DEC} |=>
        addr == {{4{$past(flag)}} & $past(bank), $past(reg_h), $past(reg_l)})
        else $error("primary pair address is wrong");
    // Secondary and mixed pairs always land in bank 0.
    fixed_pair_a: assert property (req && op inside {mba_pkg::OP_DE, mba_pkg::OP_DL} |=>
        addr[11:8] == 4'h0 && addr[7:4] == $past(reg_d) && addr[3:0] ==
        ($past(op) == mba_pkg::OP_DE ? $past(reg_e) : $past(reg_l)))
        else $error("pair address left bank 0");
    // Fixed bit area reaches only the two sixteen-nibble windows.
    fmem_area_a: assert property (req && op == mba_pkg::OP_FMEM |=>
        addr[11:8] == 4'hf && addr[7:4] inside {4'hb, 4'hf} && addr[3:0] == $past(operand[3:0]))
        else $error("fixed bit address out of area");
    // Port bit area takes nibble and bit number from operand and low index register.
    pmem_addr_a: assert property (req && op == mba_pkg::OP_PMEM |=>
        addr == {6'h3f, $past(operand[5:2]), $past(reg_l[3:2])} && bit_num == $past(reg_l[1:0]))
        else $error("port bit address is wrong");
    // Relative bit form joins effective bank, high index and operand nibble.
    hrel_addr_a: assert property (req && op == mba_pkg::OP_HREL |=>
        addr == {{4{$past(flag)}} & $past(bank), $past(reg_h), $past(operand[3:0])})
        else $error("relative bit address is wrong");
    // Stack accesses stay in banks 0 to 3 at the pointer.
    stack_addr_a: assert property (req && op == mba_pkg::OP_STACK |=>
        addr[11:10] == 2'b00 && addr[7:0] == $past(sp))
        else $error("stack address is wrong");
    // Selects only rise inside the RAM or peripheral ranges.
    space_decode_a: assert property (ack |-> !(ram_sel && per_sel) &&
        (!ram_sel || addr <= 12'h3ff) && (!per_sel || addr >= 12'hf80))
        else $error("space select outside its range");
    // The select value never holds an unsupported bank.
    bank_legal_a: assert property (bank inside {4'h0, 4'h1, 4'h2, 4'h3, 4'hf})
        else $error("bank select holds illegal value");
    // Legal select loads show up with the answer.
    sel_load_a: assert property (req && op == mba_pkg::OP_SEL_BANK &&
        operand[3:0] inside {4'h0, 4'h1, 4'h2, 4'h3, 4'hf} |=> bank == $past(operand[3:0]))
        else $error("bank select not loaded");
    // Set and clear commands move the enable flag singly.
    flag_ops_a: assert property (req && op inside {mba_pkg::OP_SET_EN,
        mba_pkg::OP_CLR_EN} |=> flag == ($past(op) == mba_pkg::OP_SET_EN))
        else $error("enable flag not updated");
endmodule

// File: testbench.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin fail_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
    // Clock, reset, APB and bench state.
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] st;
    logic        err;
    logic [11:0] mem_addr;
    int          fail_count;
    int          n_checks;

    mba_if link ();

    mba_host mba_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link.host));
    mba_device mba_device_inst (.pclk(pclk), .presetn(presetn), .link(link.dev),
        .mem_strobe(), .mem_addr(mem_addr), .mem_bit(), .mem_wide(), .ram_cs(), .per_cs(),
        .bank_enable_flag(), .bank_select_value(), .stack_bank_select());
    mba_assertions mba_assertions_inst (.pclk(pclk), .presetn(presetn), .req(link.req),
        .op(link.op), .wide(link.wide), .operand(link.operand), .bitsel(link.bitsel),
        .reg_h(link.reg_h), .reg_l(link.reg_l), .reg_d(link.reg_d), .reg_e(link.reg_e),
        .sp(link.sp), .ack(link.ack), .addr(link.addr), .bit_num(link.bit_num),
        .ram_sel(link.ram_sel), .per_sel(link.per_sel), .fault(link.fault),
        .flag(link.flag), .bank(link.bank));

    // Free running 20 MHz clock.
    always #25 pclk = ~pclk;

    // One APB transfer, held until pready is sampled high.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d = 32'h0000_0000);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        st = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Launches a command and polls status until the controller is idle.
    task run(input mba_pkg::mba_op_t o, input logic [7:0] d = 8'h00, input logic w = 1'b0);
        apb(1'b1, mba_pkg::OFF_CMD, {16'h0000, d, 3'b000, w, o});
        apb(1'b0, mba_pkg::OFF_STATUS);
        while (st[mba_pkg::ST_BUSY] !== 1'b0) apb(1'b0, mba_pkg::OFF_STATUS);
    endtask

    // Compares address, select pair {per, ram} and fault of the last status.
    task look(input logic [11:0] a, input logic [1:0] sel, input logic f = 1'b0);
        `CHK(st[11:0], a)
        `CHK(mem_addr, a)
        `CHK(st[15:14], sel)
        `CHK(st[16], f)
    endtask

    // Reset state and a refused access to an unmapped offset.
    task t_reset;
        apb(1'b0, mba_pkg::OFF_STATUS);
        `CHK(st, 32'h0000_0000)
        apb(1'b0, 12'h00c);
        `CHK(err, 1'b1)
        $display("reset test done");
    endtask

    // Direct forms with the flag clear and set, plus byte alignment.
    task t_direct;
        run(mba_pkg::OP_SEL_BANK, 8'h02);
        run(mba_pkg::OP_CLR_EN);
        run(mba_pkg::OP_DIR, 8'h7f);
        look(12'h07f, 2'b01);
        run(mba_pkg::OP_DIR, 8'h80);
        look(12'hf80, 2'b10);
        run(mba_pkg::OP_SET_EN);
        run(mba_pkg::OP_DIR, 8'h45);
        look(12'h245, 2'b01);
        run(mba_pkg::OP_SEL_BANK, 8'h0f);
        run(mba_pkg::OP_DIR, 8'h10);
        look(12'hf10, 2'b00);
        run(mba_pkg::OP_DIR, 8'h21, 1'b1);
        `CHK(st[16], 1'b1)
        run(mba_pkg::OP_DIR, 8'hfe, 1'b1);
        look(12'hffe, 2'b10);
        $display("direct test done");
    endtask

    // Every select value, legal and illegal, then the flag commands.
    task t_select;
        logic [3:0] exp_bank;
        exp_bank = 4'hf;
        for (int i = 0; i < 16; i++) begin
            run(mba_pkg::OP_SEL_BANK, 8'(i));
            if (i < 4 || i == 15) exp_bank = 4'(i);
            `CHK(st[23:20], exp_bank)
            `CHK(st[16], !(i < 4 || i == 15))
        end
        run(mba_pkg::OP_CLR_EN);
        `CHK(st[18], 1'b0)
        run(mba_pkg::OP_SET_EN);
        `CHK(st[18], 1'b1)
        $display("select test done");
    endtask

    // Pair based indirect forms and the relative bit form.
    task t_index;
        apb(1'b1, mba_pkg::OFF_INDEX, 32'h005c_c35a);
        run(mba_pkg::OP_SEL_BANK, 8'h02);
        run(mba_pkg::OP_HL);
        look(12'h2a5, 2'b01);
        run(mba_pkg::OP_HL_INC);
        look(12'h2a5, 2'b01);
        apb(1'b0, mba_pkg::OFF_INDEX);
        `CHK(st[7:0], 8'h6a)
        run(mba_pkg::OP_HL_DEC);
        look(12'h2a6, 2'b01);
        run(mba_pkg::OP_HL, 8'h00, 1'b1);
        `CHK(st[16], 1'b1)
        run(mba_pkg::OP_CLR_EN);
        run(mba_pkg::OP_HL);
        look(12'h0a5, 2'b01);
        run(mba_pkg::OP_HREL, 8'h37);
        look(12'h0a7, 2'b01);
        run(mba_pkg::OP_SET_EN);
        run(mba_pkg::OP_DE);
        look(12'h03c, 2'b01);
        run(mba_pkg::OP_DL);
        look(12'h035, 2'b01);
        run(mba_pkg::OP_HREL, 8'h37);
        look(12'h2a7, 2'b01);
        $display("index test done");
    endtask

    // Fixed and port bit areas, then stack bank selection.
    task t_bits;
        run(mba_pkg::OP_FMEM, 8'h45);
        look(12'hff5, 2'b10);
        run(mba_pkg::OP_FMEM, 8'h05);
        look(12'hfb5, 2'b10);
        apb(1'b1, mba_pkg::OFF_INDEX, 32'h005c_c3ea);
        run(mba_pkg::OP_PMEM, 8'h14);
        look(12'hfd7, 2'b10);
        `CHK(st[13:12], 2'b10)
        run(mba_pkg::OP_SEL_STACK, 8'h02);
        run(mba_pkg::OP_STACK);
        look(12'h25c, 2'b01);
        run(mba_pkg::OP_SEL_STACK, 8'h07);
        `CHK(st[16], 1'b1)
        run(mba_pkg::OP_STACK);
        look(12'h35c, 2'b01);
        $display("bits test done");
    endtask

    // Nested save and restore of the enable flag.
    task t_call;
        run(mba_pkg::OP_SET_EN);
        run(mba_pkg::OP_CALL);
        run(mba_pkg::OP_CLR_EN);
        run(mba_pkg::OP_CALL);
        run(mba_pkg::OP_SET_EN);
        run(mba_pkg::OP_RET);
        `CHK(st[18], 1'b0)
        run(mba_pkg::OP_RET);
        `CHK(st[18], 1'b1)
        run(mba_pkg::OP_RET);
        `CHK(st[18], 1'b0)
        $display("call test done");
    endtask

    // Prints the counts and the verdict, then stops.
    task end_of_test;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Cuts a hang short well after the tests should have ended.
    initial begin
        #200_000;
        fail_count++;
        end_of_test();
    end

    // Reset, then the scenarios in order.
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        fail_count = 0;
        n_checks = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_direct();
        t_select();
        t_index();
        t_bits();
        t_call();
        end_of_test();
    end
endmodule
